//--- hw/pnv_port.sv
// parallel programming port of the nonvolatile memories
`timescale 1ns/1ps
module pnv_port #(
  // identity bytes: values are arbitrary
  parameter logic [7:0]  SIG_ID0     = 8'h5A,
  parameter logic [7:0]  SIG_ID1     = 8'hA5,
  parameter logic [7:0]  SIG_ID2     = 8'h3C,
  // calibration row, byte 0 is the fast oscillator
  parameter logic [63:0] CAL_ROW     = 64'h8080808080808080,
  // words walked by chip erase; shorten in simulation
  parameter logic [15:0] ERASE_WORDS = pnv_pkg::FLASH_WORDS
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // programming mode level
  input  wire logic       progMode,
  // programmer control pins
  input  wire logic       crystalInStrobe,
  input  wire logic       actionSelect0,
  input  wire logic       actionSelect1,
  input  wire logic       byteSelectOne,
  input  wire logic       byteSelectTwo,
  input  wire logic       pageLoadStrobe,
  input  wire logic       writeStrobe_n,
  input  wire logic       outputEnable_n,
  // data bus
  input  wire logic [7:0] dataIn,
  output logic      [7:0] dataOut,
  output logic            dataOe,
  // status
  output logic            readyBusyOut,
  // latched fuse settings; eeprom keep also follows the live low fuse
  output logic            debugEnableFuse,
  output logic            scanPortEnableFuse,
  output logic            watchdogForceOnFuse,
  output logic            eepromKeepFuse,
  output logic            bootSizeHi,
  output logic            bootSizeLo,
  output logic            resetVectorSelect,
  output logic            startupTimeHi,
  output logic            startupTimeLo,
  output logic            clockSourceSelect,
  output logic      [7:0] lockBits,
  output logic      [7:0] fastOscCal
);

  logic                rstMeta;
  logic                rstN;
  logic                xtalPrev;
  logic                wrPrev;
  logic                pagePrev;
  logic                progPrev;
  logic [7:0]          cmd;
  logic [7:0]          addrLow;
  logic [7:0]          addrHigh;
  logic [7:0]          dataLow;
  logic [7:0]          dataHigh;
  logic [7:0]          fuseHigh;
  logic [7:0]          fuseLow;
  logic [7:0]          latchedHigh;
  logic [7:0]          latchedLow;
  logic                latchPending;
  logic                pageDirty;
  logic [7:0]          eeBuf [pnv_pkg::EE_PAGE_BYTES];
  logic [15:0]         cnt;
  pnv_pkg::pnv_state_t state;
  logic [15:0]         flashRd;
  logic [15:0]         pageRd;
  logic [7:0]          eeRd;

  // release the reset through two flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  // strobe edges; pins are synchronous, so no filter is needed
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      xtalPrev <= 1'b0;
      wrPrev   <= 1'b1;
      pagePrev <= 1'b0;
      progPrev <= 1'b0;
    end
    else
    begin
      xtalPrev <= crystalInStrobe;
      wrPrev   <= writeStrobe_n;
      pagePrev <= pageLoadStrobe;
      progPrev <= progMode;
    end
  end

  wire xtalRise = crystalInStrobe & ~xtalPrev;
  wire wrFall   = ~writeStrobe_n & wrPrev;
  wire pageRise = pageLoadStrobe & ~pagePrev;
  wire progRise = progMode & ~progPrev;
  wire [1:0] action = {actionSelect1, actionSelect0};
  wire idle     = (state == pnv_pkg::ST_IDLE);

  wire cmdErase  = (cmd == pnv_pkg::CMD_ERASE);
  wire cmdFuseWr = (cmd == pnv_pkg::CMD_FUSE_WR);
  wire cmdLockWr = (cmd == pnv_pkg::CMD_LOCK_WR);
  wire cmdFlashWr = (cmd == pnv_pkg::CMD_FLASH_WR);
  wire cmdEeWr    = (cmd == pnv_pkg::CMD_EE_WR);
  wire cmdSigRd   = (cmd == pnv_pkg::CMD_SIG_RD);
  wire cmdFuseRd  = (cmd == pnv_pkg::CMD_FUSE_RD);
  wire cmdFlashRd = (cmd == pnv_pkg::CMD_FLASH_RD);
  wire cmdEeRd    = (cmd == pnv_pkg::CMD_EE_RD);

  // lock mode 2 or 3 stops programming, mode 3 stops reading too
  wire progLocked = ~lockBits[pnv_pkg::LOCK_ONE_BIT];
  wire readLocked = progLocked & ~lockBits[pnv_pkg::LOCK_TWO_BIT];

  wire [15:0] fullAddr = {addrHigh, addrLow};
  wire [pnv_pkg::FLASH_AW-1:0] flashAddr =
    fullAddr[pnv_pkg::FLASH_ADDR_TOP:0];
  wire [pnv_pkg::WORD_BITS-1:0] wordInPage =
    fullAddr[pnv_pkg::WORD_BITS-1:0];
  wire flashAddrOk = (fullAddr < pnv_pkg::FLASH_WORDS);
  wire [pnv_pkg::EE_AW-1:0] eepromAddress =
    fullAddr[pnv_pkg::EE_ADDR_TOP:0];
  wire [pnv_pkg::EE_WORD_BITS-1:0] eeInPage =
    fullAddr[pnv_pkg::EE_WORD_BITS-1:0];

  // write strobe start conditions; busy strobes are ignored
  wire wrTake     = wrFall & idle;
  wire startErase = wrTake & cmdErase;
  wire startFlash = wrTake & cmdFlashWr & pageDirty & ~progLocked
                  & flashAddrOk;
  wire startEe    = wrTake & cmdEeWr & pageDirty & ~progLocked;
  // lock bit one refuses fuse writes
  wire fuseWrOk   = wrTake & cmdFuseWr & ~progLocked;
  wire fuseHighWr = fuseWrOk & byteSelectOne & ~byteSelectTwo;
  wire fuseLowWr  = fuseWrOk & ~byteSelectOne;
  wire lockWr     = wrTake & cmdLockWr;

  wire pageWe   = pageRise & idle & cmdFlashWr;
  wire eeBufWe  = pageRise & idle & cmdEeWr;

  wire [15:0] cntPrev = cnt - 16'h0001;
  wire eraseLast = (cnt == ERASE_WORDS - 16'h0001);
  wire flashLast = (cnt == pnv_pkg::PAGE_LAST);
  wire eeLast    = (cnt == pnv_pkg::EE_PG_LAST);
  wire inErase   = (state == pnv_pkg::ST_ERASE);
  wire inFprog   = (state == pnv_pkg::ST_FPROG);
  wire inEprog   = (state == pnv_pkg::ST_EPROG);

  wire keepNow = latchedLow[pnv_pkg::FL_KEEP_BIT]
               & fuseLow[pnv_pkg::FL_KEEP_BIT];

  // flash write port: erase walk or page copy
  wire flashWe = inErase | (inFprog & (cnt != 16'h0000));
  wire [pnv_pkg::FLASH_AW-1:0] flashWa = inErase
    ? cnt[pnv_pkg::FLASH_AW-1:0]
    : {flashAddr[pnv_pkg::FLASH_ADDR_TOP:pnv_pkg::WORD_BITS],
       cntPrev[pnv_pkg::WORD_BITS-1:0]};
  wire [15:0] flashWd = inErase ? pnv_pkg::WORD_ERASED : pageRd;

  // eeprom write port: erase walk unless kept, or page copy
  wire eeWe = (inErase & (cnt < pnv_pkg::EE_LIMIT) & keepNow) | inEprog;
  wire [pnv_pkg::EE_AW-1:0] eeWa = inErase
    ? cnt[pnv_pkg::EE_AW-1:0]
    : {eepromAddress[pnv_pkg::EE_ADDR_TOP:pnv_pkg::EE_WORD_BITS],
       cnt[pnv_pkg::EE_WORD_BITS-1:0]};
  wire [7:0] eeWd = inErase ? pnv_pkg::BYTE_ERASED
                  : eeBuf[cnt[pnv_pkg::EE_WORD_BITS-1:0]];

  pnv_mem #(
    .WIDTH(16),
    .DEPTH(int'(pnv_pkg::FLASH_WORDS)),
    .AW   (pnv_pkg::FLASH_AW)
  ) flashMem (
    .clk(clk),
    .we (flashWe),
    .wa (flashWa),
    .wd (flashWd),
    .ra (flashAddr),
    .rd (flashRd)
  );

  pnv_mem #(
    .WIDTH(16),
    .DEPTH(pnv_pkg::PAGE_WORDS),
    .AW   (pnv_pkg::WORD_BITS)
  ) pageMem (
    .clk(clk),
    .we (pageWe),
    .wa (wordInPage),
    .wd ({dataHigh, dataLow}),
    .ra (cnt[pnv_pkg::WORD_BITS-1:0]),
    .rd (pageRd)
  );

  pnv_mem #(
    .WIDTH(8),
    .DEPTH(pnv_pkg::EE_BYTES),
    .AW   (pnv_pkg::EE_AW)
  ) eeMem (
    .clk(clk),
    .we (eeWe),
    .wa (eeWa),
    .wd (eeWd),
    .ra (eepromAddress),
    .rd (eeRd)
  );

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      cmd      <= pnv_pkg::CMD_NOP;
      addrLow  <= 8'h00;
      addrHigh <= 8'h00;
      dataLow  <= 8'hFF;
      dataHigh <= 8'hFF;
    end
    else if (xtalRise)
    begin
      case (action)
        pnv_pkg::ACT_ADDR:
        begin
          if (byteSelectOne)
            addrHigh <= dataIn;
          else
            addrLow <= dataIn;
        end
        pnv_pkg::ACT_DATA:
        begin
          if (byteSelectOne)
            dataHigh <= dataIn;
          else
            dataLow <= dataIn;
        end
        pnv_pkg::ACT_CMD:  cmd <= dataIn;
        default:           cmd <= cmd;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      pageDirty <= 1'b0;
    else if (pageWe | eeBufWe)
      pageDirty <= 1'b1;
    else if ((xtalRise & (action == pnv_pkg::ACT_CMD)
              & (dataIn == pnv_pkg::CMD_NOP)) | startFlash | startEe)
      pageDirty <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      for (int i = 0; i < pnv_pkg::EE_PAGE_BYTES; i++)
        eeBuf[i] <= pnv_pkg::BYTE_ERASED;
    end
    else if (eeBufWe)
      eeBuf[eeInPage] <= dataLow;
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state <= pnv_pkg::ST_IDLE;
      cnt   <= 16'h0000;
    end
    else
    begin
      case (state)
        pnv_pkg::ST_IDLE:
        begin
          cnt <= 16'h0000;
          if (startErase)
            state <= pnv_pkg::ST_ERASE;
          else if (startFlash)
            state <= pnv_pkg::ST_FPROG;
          else if (startEe)
            state <= pnv_pkg::ST_EPROG;
          else
            state <= pnv_pkg::ST_IDLE;
        end
        pnv_pkg::ST_ERASE:
        begin
          cnt <= cnt + 16'h0001;
          if (eraseLast)
            state <= pnv_pkg::ST_IDLE;
        end
        pnv_pkg::ST_FPROG:
        begin
          cnt <= cnt + 16'h0001;
          if (flashLast)
            state <= pnv_pkg::ST_IDLE;
        end
        pnv_pkg::ST_EPROG:
        begin
          cnt <= cnt + 16'h0001;
          if (eeLast)
            state <= pnv_pkg::ST_IDLE;
        end
        default:
          state <= pnv_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      fuseHigh <= pnv_pkg::FUSE_HIGH_RESET;
      fuseLow  <= pnv_pkg::FUSE_LOW_RESET;
    end
    else
    begin
      if (fuseHighWr)
        fuseHigh <= dataLow | ~pnv_pkg::FUSE_HIGH_USED;
      if (fuseLowWr)
        fuseLow <= dataLow;
    end
  end

  // lock bits only program; erase clears them on the clock of its last erased word
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      lockBits <= pnv_pkg::LOCK_RESET;
    else if (inErase & eraseLast)
      lockBits <= pnv_pkg::LOCK_RESET;
    else if (lockWr)
      lockBits <= lockBits & dataLow;
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      latchPending <= 1'b1;
      latchedHigh  <= pnv_pkg::FUSE_HIGH_RESET;
      latchedLow   <= pnv_pkg::FUSE_LOW_RESET;
      fastOscCal   <= 8'h00;
      eepromKeepFuse <= 1'b1;
    end
    else
    begin
      latchPending <= 1'b0;
      eepromKeepFuse <= keepNow;
      if (latchPending | progRise)
      begin
        latchedHigh <= fuseHigh;
        latchedLow  <= fuseLow;
      end
      if (latchPending)
        fastOscCal <= CAL_ROW[7:0];
    end
  end

  assign debugEnableFuse     = latchedHigh[pnv_pkg::FH_DEBUG_BIT];
  assign scanPortEnableFuse  = latchedHigh[pnv_pkg::FH_SCAN_BIT];
  assign watchdogForceOnFuse = latchedLow[pnv_pkg::FL_WDOG_BIT];
  assign bootSizeHi          = latchedLow[pnv_pkg::FL_BOOT_HI];
  assign bootSizeLo          = latchedLow[pnv_pkg::FL_BOOT_LO];
  assign resetVectorSelect   = latchedLow[pnv_pkg::FL_RSTVEC_BIT];
  assign startupTimeHi       = latchedLow[pnv_pkg::FL_SUT_HI];
  assign startupTimeLo       = latchedLow[pnv_pkg::FL_SUT_LO];
  assign clockSourceSelect   = latchedLow[pnv_pkg::FL_CLKSRC_BIT];

  wire [7:0] sigByte =
    (addrLow == pnv_pkg::SIG_ADDR0) ? SIG_ID0 :
    (addrLow == pnv_pkg::SIG_ADDR1) ? SIG_ID1 :
    (addrLow == pnv_pkg::SIG_ADDR2) ? SIG_ID2 : pnv_pkg::BYTE_ERASED;
  wire [7:0] calByte = CAL_ROW[{addrLow[2:0], 3'h0} +: 8];
  wire [7:0] sigRead = byteSelectOne ? calByte : sigByte;

  wire [7:0] fuseRead =
    ({byteSelectTwo, byteSelectOne} == 2'h0) ? fuseLow :
    ({byteSelectTwo, byteSelectOne} == 2'h1) ? fuseHigh :
    ({byteSelectTwo, byteSelectOne} == 2'h2) ? lockBits
                                             : pnv_pkg::BYTE_ERASED;

  wire [7:0] flashByte = byteSelectOne ? flashRd[15:8] : flashRd[7:0];
  wire       memBlind  = readLocked | ~idle;
  wire [7:0] readByte =
    cmdFlashRd ? ((memBlind | ~flashAddrOk) ? pnv_pkg::BYTE_ERASED
                                            : flashByte) :
    cmdEeRd    ? (memBlind ? pnv_pkg::BYTE_ERASED : eeRd) :
    cmdSigRd   ? sigRead :
    cmdFuseRd  ? fuseRead : pnv_pkg::BYTE_ERASED;

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      dataOe  <= 1'b0;
      dataOut <= 8'h00;
    end
    else
    begin
      dataOe  <= ~outputEnable_n;
      dataOut <= readByte;
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      readyBusyOut <= 1'b0;
    else
      readyBusyOut <= idle & ~(startErase | startFlash | startEe);
  end

endmodule

//--- hw/pnv_pkg.sv
// constants, encodings and state type of the parallel programming port
// Functional notes
// - fuse reads 0 programmed, 1 unprogrammed
// - high fuse: debug bit1, scan bit0
// - low fuse: watchdog, eeprom keep, boot size
// - low fuse: reset vector, startup time field
// - low fuse bit0 selects clock source
// - chip erase leaves fuses unchanged
// - lock bit one blocks fuse changes
// - fuses latched at power-up and mode entry; eeprom keep also follows the live low fuse
// - three identity bytes, readable even locked
// - calibration row; fast oscillator byte auto-loaded
// - flash 320 pages of 64 words
// - eeprom 128 pages of 4 bytes
// - crystal strobe loads address, data, command
// - write or output strobe runs command
// - erase, fuse write, lock write encodings
// - flash write, eeprom write, signature read
// - fuse read, flash read, eeprom read
// - ready/busy low while programming
// - device drives data only while oe low
// - byte selects choose low/high fuse/lock bits
// - page load latches data into buffer
// - write strobe starts operation, busy low
// - command zero is nop, clears write state
package pnv_pkg;

  localparam logic [7:0] FUSE_HIGH_RESET = 8'hFE;
  localparam logic [7:0] FUSE_HIGH_USED  = 8'h03;
  localparam logic [7:0] FUSE_LOW_RESET  = 8'hCD;
  localparam logic [7:0] LOCK_RESET      = 8'hFF;
  localparam logic [7:0] BYTE_ERASED     = 8'hFF;
  localparam logic [15:0] WORD_ERASED    = 16'hFFFF;

  localparam int FH_DEBUG_BIT  = 1;
  localparam int FH_SCAN_BIT   = 0;
  localparam int FL_WDOG_BIT   = 7;
  localparam int FL_KEEP_BIT   = 6;
  localparam int FL_BOOT_HI    = 5;
  localparam int FL_BOOT_LO    = 4;
  localparam int FL_RSTVEC_BIT = 3;
  localparam int FL_SUT_HI     = 2;
  localparam int FL_SUT_LO     = 1;
  localparam int FL_CLKSRC_BIT = 0;
  localparam int LOCK_ONE_BIT  = 0;
  localparam int LOCK_TWO_BIT  = 1;

  localparam logic [7:0] CMD_NOP       = 8'h00;
  localparam logic [7:0] CMD_ERASE     = 8'h80;
  localparam logic [7:0] CMD_FUSE_WR   = 8'h40;
  localparam logic [7:0] CMD_LOCK_WR   = 8'h20;
  localparam logic [7:0] CMD_FLASH_WR  = 8'h10;
  localparam logic [7:0] CMD_EE_WR     = 8'h11;
  localparam logic [7:0] CMD_SIG_RD    = 8'h08;
  localparam logic [7:0] CMD_FUSE_RD   = 8'h04;
  localparam logic [7:0] CMD_FLASH_RD  = 8'h02;
  localparam logic [7:0] CMD_EE_RD     = 8'h03;

  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;

  localparam logic [15:0] FLASH_WORDS = 16'h5000;
  localparam int FLASH_AW       = 15;
  localparam int FLASH_ADDR_TOP = 14;
  localparam int PAGE_WORDS     = 64;
  localparam int WORD_BITS      = 6;
  localparam logic [15:0] PAGE_LAST = 16'h0040;
  localparam int EE_BYTES       = 512;
  localparam int EE_AW          = 9;
  localparam int EE_ADDR_TOP    = 8;
  localparam int EE_PAGE_BYTES  = 4;
  localparam int EE_WORD_BITS   = 2;
  localparam logic [15:0] EE_LIMIT   = 16'h0200;
  localparam logic [15:0] EE_PG_LAST = 16'h0003;

  localparam logic [7:0] SIG_ADDR0 = 8'h00;
  localparam logic [7:0] SIG_ADDR1 = 8'h01;
  localparam logic [7:0] SIG_ADDR2 = 8'h02;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ERASE = 4'b0010,
    ST_FPROG = 4'b0100,
    ST_EPROG = 4'b1000
  } pnv_state_t;

endpackage

//--- hw/pnv_mem.sv
// simple dual-port memory with registered read data
`timescale 1ns/1ps
module pnv_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  // clock
  input  wire logic             clk,
  // write port
  input  wire logic             we,
  input  wire logic [AW-1:0]    wa,
  input  wire logic [WIDTH-1:0] wd,
  // read port
  input  wire logic [AW-1:0]    ra,
  output logic      [WIDTH-1:0] rd
);

  // no reset: contents must survive a device reset
  logic [WIDTH-1:0] store [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      store[wa] <= wd;
    end
    rd <= store[ra];
  end

endmodule

//--- bench/pnv_port_chk.sv
// assertion checker for the parallel programming port
`timescale 1ns/1ps
module pnv_port_chk #(
  parameter logic [63:0] CAL_ROW     = 64'h8080808080808080,
  parameter logic [15:0] ERASE_WORDS = 16'h5000
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // programmer pins
  input wire logic       progMode,
  input wire logic       writeStrobe_n,
  input wire logic       outputEnable_n,
  // bus and status
  input wire logic       dataOe,
  input wire logic       readyBusyOut,
  // latched fuses
  input wire logic       debugEnableFuse,
  input wire logic       scanPortEnableFuse,
  input wire logic       watchdogForceOnFuse,
  input wire logic       bootSizeHi,
  input wire logic       bootSizeLo,
  input wire logic       resetVectorSelect,
  input wire logic       startupTimeHi,
  input wire logic       startupTimeLo,
  input wire logic       clockSourceSelect,
  input wire logic [7:0] fastOscCal
);
  logic [3:0]  progHist;
  logic [2:0]  upCnt;
  logic [15:0] busyCnt;
  wire  [8:0]  fuseVec = {debugEnableFuse, scanPortEnableFuse,
    watchdogForceOnFuse, bootSizeHi, bootSizeLo, resetVectorSelect,
    startupTimeHi, startupTimeLo, clockSourceSelect};
  // latch latency is one cycle, so a short window is allowed
  wire         recentRise = |({progHist[2:0], progMode} & ~progHist);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      progHist <= 4'h0;
      upCnt    <= 3'h0;
      busyCnt  <= 16'h0;
    end
    else
    begin
      progHist <= {progHist[2:0], progMode};
      upCnt    <= (upCnt == 3'h7) ? upCnt : upCnt + 3'h1;
      busyCnt  <= readyBusyOut ? 16'h0 : busyCnt + 16'h1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence wrFallSeen;
    $past(writeStrobe_n, 2) && !$past(writeStrobe_n);
  endsequence
  sequence oeLowSeen;
    !$past(outputEnable_n);
  endsequence

  a_oe_only_low: assert property (dataOe |-> oeLowSeen)
    else $error("bus driven, oe high");
  a_oe_drives: assert property ($fell(outputEnable_n) |=> dataOe)
    else $error("bus not driven, oe low");
  a_busy_start: assert property ($fell(readyBusyOut) |-> wrFallSeen)
    else $error("busy without strobe");
  a_busy_bound: assert property
    (!readyBusyOut |-> busyCnt <= ERASE_WORDS + 16'h0004)
    else $error("busy too long");
  a_fuse_latch: assert property ($changed(fuseVec) |-> recentRise)
    else $error("fuses changed off entry");
  a_ready_up: assert property (upCnt == 3'h4 |-> readyBusyOut)
    else $error("not ready after reset");
  a_cal_loaded: assert property
    (upCnt >= 3'h4 |-> fastOscCal == CAL_ROW[7:0])
    else $error("calibration not loaded");
  a_cal_early: assert property (upCnt <= 3'h2 |-> fastOscCal == 8'h00)
    else $error("calibration too early");
  a_fuse_default: assert property
    (upCnt <= 3'h3 |-> fuseVec == 9'h14D)
    else $error("fuse defaults wrong");
endmodule

bind pnv_port pnv_port_chk #(.CAL_ROW(CAL_ROW), .ERASE_WORDS(ERASE_WORDS)) chk (
  .*);

//--- bench/pnv_prog_model.sv
// programmer model driving the parallel programming pins
`timescale 1ns/1ps
module pnv_prog_model #(
  parameter int PW = 63
) (
  // clock
  input  wire logic       clk,
  // device bus side
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOe,
  // pins toward the device
  output logic            progMode,
  output logic            crystalInStrobe,
  output logic            actionSelect0,
  output logic            actionSelect1,
  output logic            byteSelectOne,
  output logic            byteSelectTwo,
  output logic            pageLoadStrobe,
  output logic            writeStrobe_n,
  output logic            outputEnable_n,
  output logic      [7:0] dataIn
);
  logic       drive;
  logic [7:0] drvData;
  logic [7:0] lastBus;
  // a released bus toggles, so a stale byte can never pass as read data
  // bus ownership
  assign dataIn = dataOe ? dataOut : (drive ? drvData : ~lastBus);
  always @(posedge clk) lastBus <= dataIn;

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic xtal(input logic [1:0] act, input logic bs1,
                      input logic [7:0] d);
    {actionSelect1, actionSelect0} = act;
    byteSelectOne = bs1;
    drvData = d;
    drive = 1'b1;
    step(1);
    crystalInStrobe = 1'b1;
    step(PW);
    crystalInStrobe = 1'b0;
    step(PW);
    drive = 1'b0;
  endtask
  task automatic pageLoad();
    pageLoadStrobe = 1'b1;
    step(PW);
    pageLoadStrobe = 1'b0;
    step(PW);
  endtask
  task automatic write(input logic bs1, input logic bs2);
    byteSelectOne = bs1;
    byteSelectTwo = bs2;
    step(1);
    writeStrobe_n = 1'b0;
    step(PW);
    writeStrobe_n = 1'b1;
    step(2);
  endtask
  task automatic read(input logic bs1, input logic bs2,
                      output logic [7:0] q);
    byteSelectOne = bs1;
    byteSelectTwo = bs2;
    outputEnable_n = 1'b0;
    step(4);
    q = dataIn;
    outputEnable_n = 1'b1;
    step(2);
  endtask
  task automatic enter();
    {pageLoadStrobe, actionSelect1, actionSelect0, byteSelectOne} = 4'h0;
    progMode = 1'b0;
    step(4);
    progMode = 1'b1;
    step(4);
  endtask

  initial
  begin
    {progMode, crystalInStrobe, actionSelect0, actionSelect1} = 4'h0;
    {byteSelectOne, byteSelectTwo, pageLoadStrobe} = 3'h0;
    {writeStrobe_n, outputEnable_n} = 2'h3;
    drive = 1'b0;
    drvData = 8'h00;
    lastBus = 8'h00;
  end
endmodule

//--- bench/tb.sv
// self-checking testbench of the parallel programming port
`timescale 1ns/1ps
module tb;
  localparam logic [15:0] ERASE_N = 16'h0200;
  // identity bytes: values are arbitrary
  localparam logic [7:0]  ID0 = 8'h6B;
  localparam logic [7:0]  ID1 = 8'h2D;
  localparam logic [7:0]  ID2 = 8'h94;
  localparam logic [63:0] CAL = 64'h1122334455667788;
  logic       clk, rst_n, progMode, crystalInStrobe, actionSelect0;
  logic       actionSelect1, byteSelectOne, byteSelectTwo, pageLoadStrobe;
  logic       writeStrobe_n, outputEnable_n, dataOe, readyBusyOut;
  logic       debugEnableFuse, scanPortEnableFuse, watchdogForceOnFuse;
  logic       eepromKeepFuse, bootSizeHi, bootSizeLo, resetVectorSelect;
  logic       startupTimeHi, startupTimeLo, clockSourceSelect;
  logic [7:0] dataIn, dataOut, lockBits, fastOscCal, q;
  logic [7:0] idTab [4] = '{ID0, ID1, ID2, 8'hFF};
  int         miscompares, checked, busyRun, lastBusy;
  wire  [7:0] fuseLo = {watchdogForceOnFuse, eepromKeepFuse, bootSizeHi,
    bootSizeLo, resetVectorSelect, startupTimeHi, startupTimeLo,
    clockSourceSelect};
  wire  [7:0] fuseHi = {6'h3F, debugEnableFuse, scanPortEnableFuse};

  pnv_port #(.SIG_ID0(ID0), .SIG_ID1(ID1), .SIG_ID2(ID2), .CAL_ROW(CAL),
    .ERASE_WORDS(ERASE_N)) dut (.clk(clk), .rst_n(rst_n),
    .progMode(progMode), .crystalInStrobe(crystalInStrobe),
    .actionSelect0(actionSelect0), .actionSelect1(actionSelect1),
    .byteSelectOne(byteSelectOne), .byteSelectTwo(byteSelectTwo),
    .pageLoadStrobe(pageLoadStrobe), .writeStrobe_n(writeStrobe_n),
    .outputEnable_n(outputEnable_n), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .readyBusyOut(readyBusyOut),
    .debugEnableFuse(debugEnableFuse),
    .scanPortEnableFuse(scanPortEnableFuse),
    .watchdogForceOnFuse(watchdogForceOnFuse),
    .eepromKeepFuse(eepromKeepFuse), .bootSizeHi(bootSizeHi),
    .bootSizeLo(bootSizeLo), .resetVectorSelect(resetVectorSelect),
    .startupTimeHi(startupTimeHi), .startupTimeLo(startupTimeLo),
    .clockSourceSelect(clockSourceSelect), .lockBits(lockBits),
    .fastOscCal(fastOscCal));
  pnv_prog_model pm (.clk(clk), .dataOut(dataOut), .dataOe(dataOe),
    .progMode(progMode), .crystalInStrobe(crystalInStrobe),
    .actionSelect0(actionSelect0), .actionSelect1(actionSelect1),
    .byteSelectOne(byteSelectOne), .byteSelectTwo(byteSelectTwo),
    .pageLoadStrobe(pageLoadStrobe), .writeStrobe_n(writeStrobe_n),
    .outputEnable_n(outputEnable_n), .dataIn(dataIn));

  initial clk = 1'b0;
  always #2 clk = ~clk;
  // length of the latest busy stretch, measured at the pin
  always @(posedge clk)
    if (readyBusyOut === 1'b0) busyRun++;
    else if (busyRun != 0)
    begin
      lastBusy = busyRun;
      busyRun = 0;
    end

  task automatic print_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk8(input string n, input logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkInt(input string n, input int e, input int g);
    checked++;
    if (g != e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic wrOp(input logic bs1, input logic bs2);
    int i;
    pm.write(bs1, bs2);
    for (i = 0; i < 2000 && readyBusyOut !== 1'b1; i++) pm.step(1);
    pm.step(1);
    if (i >= 2000)
    begin
      miscompares++;
      $display("[FAIL] ready expected 1 seen timeout");
      print_verdict();
    end
  endtask
  task automatic setAddr(input logic [15:0] a);
    pm.xtal(2'h0, 1'b1, a[15:8]);
    pm.xtal(2'h0, 1'b0, a[7:0]);
  endtask
  task automatic rdChk(input string n, input logic b1, b2, [7:0] e);
    pm.read(b1, b2, q);
    chk8(n, e, q);
  endtask
  task automatic rdBack(input logic [7:0] c, input logic [15:0] a, e);
    pm.xtal(2'h2, 1'b0, c);
    setAddr(a);
    rdChk("mem low", 1'b0, 1'b0, e[7:0]);
    if (c == 8'h02) rdChk("mem high", 1'b1, 1'b0, e[15:8]);
  endtask
  task automatic noBusy(input logic [7:0] c, n);
    pm.xtal(2'h2, 1'b0, 8'h11);
    setAddr(16'h0000);
    pm.xtal(2'h1, 1'b0, 8'h33);
    pm.pageLoad();
    pm.xtal(2'h2, 1'b0, c);
    pm.xtal(2'h2, 1'b0, n);
    lastBusy = 0;
    pm.write(1'b0, 1'b0);
    chkInt("no busy", 0, lastBusy);
  endtask

  initial
  begin
    {rst_n, miscompares, checked, busyRun, lastBusy} = '0;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    pm.step(6);
    chk8("fuse low out", 8'hCD, fuseLo);
    chk8("fuse high out", 8'hFE, fuseHi);
    chk8("osc cal", CAL[7:0], fastOscCal);
    pm.enter();
    pm.xtal(2'h2, 1'b0, 8'h04);
    pm.xtal(2'h3, 1'b0, 8'h02);
    rdChk("fuse low", 1'b0, 1'b0, 8'hCD);
    rdChk("fuse high", 1'b1, 1'b0, 8'hFE);
    rdChk("lock", 1'b0, 1'b1, 8'hFF);
    pm.xtal(2'h2, 1'b0, 8'h08);
    for (int k = 0; k < 4; k++)
    begin
      setAddr({8'h00, 8'(k)});
      rdChk("id", 1'b0, 1'b0, idTab[k]);
    end
    rdChk("cal", 1'b1, 1'b0, CAL[31:24]);
    pm.xtal(2'h2, 1'b0, 8'h10);
    pm.xtal(2'h0, 1'b0, 8'hFF);
    pm.xtal(2'h1, 1'b0, 8'hEF);
    pm.xtal(2'h1, 1'b1, 8'hBE);
    pm.pageLoad();
    pm.xtal(2'h0, 1'b1, 8'h01);
    wrOp(1'b0, 1'b0);
    chkInt("flash busy", 66, lastBusy);
    pm.xtal(2'h2, 1'b0, 8'h11);
    setAddr(16'h01FF);
    pm.xtal(2'h1, 1'b0, 8'hA7);
    pm.pageLoad();
    wrOp(1'b0, 1'b0);
    chkInt("eeprom busy", 5, lastBusy);
    rdBack(8'h02, 16'h01FF, 16'hBEEF);
    rdBack(8'h03, 16'h01FF, 16'h00A7);
    pm.xtal(2'h2, 1'b0, 8'h40);
    pm.xtal(2'h1, 1'b0, 8'h85);
    wrOp(1'b0, 1'b0);
    pm.xtal(2'h1, 1'b0, 8'h00);
    wrOp(1'b1, 1'b0);
    chk8("fuse low out", 8'h8D, fuseLo);
    pm.enter();
    chk8("fuse low out", 8'h85, fuseLo);
    chk8("fuse high out", 8'hFC, fuseHi);
    pm.xtal(2'h2, 1'b0, 8'h20);
    pm.xtal(2'h1, 1'b0, 8'hFE);
    wrOp(1'b0, 1'b0);
    chk8("lock out", 8'hFE, lockBits);
    pm.xtal(2'h2, 1'b0, 8'h40);
    pm.xtal(2'h1, 1'b0, 8'hFF);
    wrOp(1'b0, 1'b0);
    pm.xtal(2'h2, 1'b0, 8'h04);
    rdChk("fuse low", 1'b0, 1'b0, 8'h85);
    pm.xtal(2'h2, 1'b0, 8'h80);
    wrOp(1'b0, 1'b0);
    chkInt("erase busy", int'(ERASE_N) + 1, lastBusy);
    chk8("lock out", 8'hFF, lockBits);
    pm.xtal(2'h2, 1'b0, 8'h04);
    rdChk("fuse high", 1'b1, 1'b0, 8'hFC);
    rdBack(8'h02, 16'h01FF, 16'hFFFF);
    rdBack(8'h03, 16'h01FF, 16'h00A7);
    noBusy(8'h55, 8'h55);
    noBusy(8'h00, 8'h11);
    print_verdict();
  end
endmodule
